// ==== reset_pin_manager_bench.sv ====
// Self-checking bench of the reset pin manager over its AXI4-Lite registers
`timescale 1ns/10ps
`include "rpm_consts.svh"
module reset_pin_manager_bench;
   localparam logic [15:0] SD = 16'h0004;
   logic        aclk, aresetn, io_supply_resetn, periph_event, press, clr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs, hit;
   logic        ext_rst_in, ext_rst_out, ext_rst_oe, cpu_reset_n, peripheral_reset_n, irq;
   int          error_cnt, tests_run, oe_cnt, k;
   logic [31:0] codes [3] = '{32'h0000_0001, 32'h0000_0004, 32'h0000_0008};
   logic [1:0]  hits  [3] = '{2'b01, 2'b11, 2'b00};

   rpm_top #(.SLOW_DIV(SD)) rpm_top_inst (
      .aclk(aclk), .aresetn(aresetn), .io_supply_resetn(io_supply_resetn), .periph_event(periph_event),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .ext_rst_in(ext_rst_in), .ext_rst_out(ext_rst_out), .ext_rst_oe(ext_rst_oe),
      .cpu_reset_n(cpu_reset_n), .peripheral_reset_n(peripheral_reset_n), .irq(irq));

   rpm_pin_model rpm_pin_model_inst (
      .ext_rst_out(ext_rst_out), .ext_rst_oe(ext_rst_oe), .press(press), .pin_level(ext_rst_in));

   // Clock of 100 MHz
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Remembers short reset pulses that a polling loop could miss
   always @(posedge aclk) begin
      if (clr) begin
         hit <= 2'b00;
         oe_cnt <= 0;
      end else begin
         if (cpu_reset_n === 1'b0) hit[0] <= 1'b1;
         if (peripheral_reset_n === 1'b0) hit[1] <= 1'b1;
         if (ext_rst_oe === 1'b1) oe_cnt <= oe_cnt + 1;
      end
   end

   task close_out;
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   // Clears the pulse monitor; one edge passes so the clear lands alone
   task clear_hits;
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
   endtask : clear_hits

   // Write: address and data offered together, each dropped once taken
   task axi_write(input logic [11:0] a, input logic [31:0] d);
      int i;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      rs = bresp;
      if (i == 100) begin
         error_cnt++;
         close_out();
      end
      tick(1);
   endtask : axi_write

   task axi_read(input logic [11:0] a);
      int i;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
      if (i == 100) begin
         error_cnt++;
         close_out();
      end
      tick(1);
   endtask : axi_read

   // Bounded wait until the processor reset output shows a level
   task wait_cpu(input logic v);
      int i;
      for (i = 0; i < 300 && cpu_reset_n !== v; i++) @(posedge aclk);
      if (i == 300) begin
         error_cnt++;
         close_out();
      end
   endtask : wait_cpu

   initial begin
      {aresetn, io_supply_resetn, periph_event, press, clr} = 5'b00001;
      {awvalid, wvalid, bready, arvalid, rready} = 5'b0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      error_cnt = 0;
      tests_run = 0;
      tick(8);
      aresetn <= 1'b1;
      io_supply_resetn <= 1'b1;
      clr <= 1'b0;
      tick(3);
      // Quiet outputs and register values after reset
      check({cpu_reset_n, peripheral_reset_n, ext_rst_out, ext_rst_oe, irq}, 32'h0000_0018);
      axi_read(`RPM_OFS_MODE);
      check(rd, `RPM_MODE_RESET);
      axi_read(`RPM_OFS_STATUS);
      check(rd, 32'h0001_0000);
      // Button press with user reset enabled resets both outputs
      clear_hits();
      press <= 1'b1;
      wait_cpu(1'b0);
      tick(20);
      press <= 1'b0;
      check(hit, 2'b11);
      wait_cpu(1'b1);
      tick(8);
      axi_read(12'h010);
      check(rs, `RPM_RESP_DECERR);
      check(rd, 32'h0000_0000);
      axi_read(`RPM_OFS_STATUS);
      check(rd, 32'h0001_0001);
      axi_read(`RPM_OFS_STATUS);
      check(rd, 32'h0001_0000);
      // User reset disabled: status follows the pin but no reset comes
      axi_write(`RPM_OFS_MODE, 32'h0000_0000);
      check(rs, `RPM_RESP_OKAY);
      clear_hits();
      press <= 1'b1;
      tick(12);
      axi_read(`RPM_OFS_STATUS);
      check(rd, 32'h0000_0001);
      press <= 1'b0;
      tick(12);
      check(hit, 2'b00);
      axi_read(`RPM_OFS_STATUS);
      // Interrupt in place of reset, masked first, then cleared by a read
      axi_write(`RPM_OFS_MODE, 32'h0000_0011);
      clear_hits();
      press <= 1'b1;
      tick(12);
      press <= 1'b0;
      tick(12);
      check({hit, irq}, 32'h0000_0000);
      axi_write(`RPM_OFS_IRQ_MASK, 32'h0000_0001);
      tick(10);
      check(irq, 1'b1);
      axi_read(`RPM_OFS_STATUS);
      check(rd, 32'h0001_0001);
      tick(2);
      check(irq, 1'b0);
      // Software requests from a table; pulse length of 2^2 slow ticks
      axi_write(`RPM_OFS_MODE, 32'h0000_0201);
      for (k = 0; k < 3; k++) begin
         clear_hits();
         axi_write(`RPM_OFS_CTRL, codes[k]);
         tick(60);
         check(hit, hits[k]);
      end
      check(oe_cnt >= 12 && oe_cnt <= 20, 1'b1);
      axi_read(`RPM_OFS_STATUS);
      check(rd, 32'h0001_0000);
      // Mode survives a core reset, but not an io supply reset
      axi_write(`RPM_OFS_MODE, 32'h0000_0211);
      aresetn <= 1'b0;
      tick(2);
      aresetn <= 1'b1;
      tick(2);
      axi_read(`RPM_OFS_MODE);
      check(rd, 32'h0000_0211);
      {aresetn, io_supply_resetn} <= 2'b00;
      tick(2);
      {aresetn, io_supply_resetn} <= 2'b11;
      tick(2);
      axi_read(`RPM_OFS_MODE);
      check(rd, `RPM_MODE_RESET);
      // Peripheral event asserts both reset outputs
      clear_hits();
      periph_event <= 1'b1;
      tick(1);
      periph_event <= 1'b0;
      tick(30);
      check(hit, 2'b11);
      close_out();
   end
endmodule : reset_pin_manager_bench

// ==== rpm_consts.svh ====
// Constants of the reset pin manager: offsets, fields, resets, timing
`ifndef RPM_CONSTS_SVH
`define RPM_CONSTS_SVH
`define RPM_OFS_MODE        12'h000
`define RPM_OFS_STATUS      12'h004
`define RPM_OFS_CTRL        12'h008
`define RPM_OFS_IRQ_MASK    12'h00C
`define RPM_BIT_URST_EN     0
`define RPM_BIT_URST_IRQ_EN 4
`define RPM_LSB_PULSE_LEN   8
`define RPM_W_PULSE_LEN     4
`define RPM_BIT_USR_STATUS  0
`define RPM_BIT_PIN_LEVEL   16
`define RPM_BIT_SRST_PROC   0
`define RPM_BIT_SRST_PERIPH 2
`define RPM_BIT_SRST_EXT    3
`define RPM_MODE_RESET      32'h0000_0001
`define RPM_SLOW_DIV        16'h0C35
`define RPM_RESP_OKAY       2'h0
`define RPM_RESP_DECERR     2'h3
`endif

// ==== rpm_pin_model.sv ====
// Board side of the external reset line: pull-up resistor and a push button
`timescale 1ns/10ps
module rpm_pin_model (
   // Pin drive from the design
   input  wire logic ext_rst_out,
   input  wire logic ext_rst_oe,
   // Push button, high while pressed
   input  wire logic press,
   // Resolved line level
   output logic      pin_level
);
   // Wired-and line; the pull-up brings it high once nobody pulls it down
   assign pin_level = !((ext_rst_oe && !ext_rst_out) || press);
endmodule : rpm_pin_model

// ==== rpm_pkg.sv ====
// Types of the reset pin manager
package rpm_pkg;
   typedef enum logic [3:0] {
      RPM_IDLE   = 4'b0001,
      RPM_ASSERT = 4'b0010,
      RPM_PULSE  = 4'b0100,
      RPM_WAIT   = 4'b1000
   } rpm_state_e;
   typedef struct packed {
      logic        urst_en;
      logic        urst_irq_en;
      logic [3:0]  pulse_len;
   } rpm_mode_s;
   typedef struct packed {
      logic        proc_n;
      logic        periph_n;
      logic        pin_oe;
   } rpm_rst_s;
endpackage : rpm_pkg

// ==== rpm_top.sv ====
// Reset pin manager with reset state manager and AXI4-Lite registers
`timescale 1ns/10ps
`include "rpm_consts.svh"

// Functional notes
// R1 - Runs on slow clock; outputs processor, peripheral reset and pin drive request
// R2 - Processor reset output also resets the watchdog
// R3 - Peripheral reset output resets all embedded peripherals
// R4 - Resets come from peripheral events, pin events or software request
// R5 - State manager decides resets and requests external pin drive
// R6 - Pin held asserted for a programmable duration when requested
// R7 - Pin driven low only on request, otherwise left as input
// R8 - Mode register kept across core resets while io supply is powered
// R9 - Pin sampled once per slow clock cycle
// R10 - Sampled low level reports a user reset to the state manager
// R11 - With user_reset_enable at 0 the pin causes no user reset
// R12 - pin_level_flag shows the current sampled pin level
// R13 - user_reset_status set as soon as pin assertion is detected
// R14 - user_reset_status cleared only by reading the status register
// R15 - With user_reset_irq_enable set, pin raises interrupt instead of reset
// R16 - Pin passes a two-flop synchroniser before any use
// R17 - Interrupt stays high while status and irq enable set; read clears; the code also requires irq_mask set
// R18 - Own pin drive is not reported as a user reset
module rpm_top
   import rpm_pkg::*;
#(
   parameter logic [15:0] SLOW_DIV = `RPM_SLOW_DIV
) (
   // Clock and synchronous reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Io supply power-on reset, the only reset of the mode register
   input  wire logic        io_supply_resetn,
   // Peripheral reset events
   input  wire logic        periph_event,
   // AXI4-Lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [11:0] s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // External reset pin, open drain
   input  wire logic        ext_rst_in,
   output logic             ext_rst_out,
   output logic             ext_rst_oe,
   // Reset outputs and interrupt
   output logic             cpu_reset_n,
   output logic             peripheral_reset_n,
   output logic             irq
);

   typedef struct packed {
      logic [15:0] div_cnt;
      logic        slow_en;
      logic        sync1;
      logic        sync2;
      logic        pin_smp;
      logic        usr_status;
      logic        irq_mask;
      rpm_state_e  state;
      logic [15:0] pulse_cnt;
      logic        ext_only;
      rpm_rst_s    rst;
      logic        irq;
      logic        aw_got;
      logic [11:0] aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } rpm_core_s;

   rpm_core_s core_reg;
   rpm_core_s core_next;
   rpm_mode_s mode_reg;
   rpm_mode_s mode_next;

   // Reset word split into fields; the struct order differs from the register layout
   localparam logic [31:0] MODE_RST = `RPM_MODE_RESET;

   // Decode of a word offset, shared by read and write paths
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `RPM_OFS_MODE) || (a == `RPM_OFS_STATUS) ||
                  (a == `RPM_OFS_CTRL) || (a == `RPM_OFS_IRQ_MASK);
   endfunction : is_mapped

   logic do_write;
   logic do_read;
   logic pin_low_evt;
   logic sw_proc;
   logic sw_periph;
   logic sw_ext;
   logic usr_trig;
   logic rd_status;

   // Register bus handshakes; one write and one read outstanding at most
   assign do_write = core_reg.aw_got && core_reg.w_got && !core_reg.bvalid;
   assign do_read  = s_axi_arvalid && s_axi_arready;
   assign rd_status = do_read && ({s_axi_araddr[11:2], 2'b00} == `RPM_OFS_STATUS); // see R14
   // Own drive masked so a controller pulse is not a user event
   assign pin_low_evt = core_reg.slow_en && !core_reg.sync2 && !core_reg.rst.pin_oe; // see R10, R18
   assign usr_trig = pin_low_evt && mode_reg.urst_en && !mode_reg.urst_irq_en; // see R11, R15
   assign sw_proc   = do_write && core_reg.aw_addr == `RPM_OFS_CTRL && core_reg.w_strb[0] &&
                      core_reg.w_data[`RPM_BIT_SRST_PROC];
   assign sw_periph = do_write && core_reg.aw_addr == `RPM_OFS_CTRL && core_reg.w_strb[0] &&
                      core_reg.w_data[`RPM_BIT_SRST_PERIPH];
   assign sw_ext    = do_write && core_reg.aw_addr == `RPM_OFS_CTRL && core_reg.w_strb[0] &&
                      core_reg.w_data[`RPM_BIT_SRST_EXT];

   // Next-state logic for everything except the mode register
   always_comb begin
      core_next = core_reg;
      // Slow clock enable from the divider
      core_next.slow_en = 1'b0;
      if (core_reg.div_cnt == 16'h0000) begin
         core_next.div_cnt = SLOW_DIV - 16'h0001;
         core_next.slow_en = 1'b1; // see R1
      end else begin
         core_next.div_cnt = core_reg.div_cnt - 16'h0001;
      end
      // Two-flop synchroniser; first stage feeds only the second
      core_next.sync1 = ext_rst_in; // see R16
      core_next.sync2 = core_reg.sync1;
      if (core_reg.slow_en) begin
         core_next.pin_smp = core_reg.sync2; // see R9
      end
      // Sticky status: read clears, a new event wins over the clear
      if (rd_status) begin
         core_next.usr_status = 1'b0; // see R14
      end
      if (pin_low_evt) begin
         core_next.usr_status = 1'b1; // see R13
      end
      // Reset state manager
      unique case (core_reg.state)
         RPM_IDLE: begin
            if (usr_trig || periph_event || sw_proc || sw_periph) begin // see R4, R5
               core_next.state    = RPM_ASSERT;
               core_next.ext_only = 1'b0;
               core_next.rst.proc_n   = 1'b0; // see R2
               core_next.rst.periph_n = !(usr_trig || periph_event || sw_periph); // see R3
            end else if (sw_ext) begin
               core_next.state    = RPM_ASSERT;
               core_next.ext_only = 1'b1;
            end
         end
         RPM_ASSERT: begin
            // Ask the pin manager for a pulse of the programmed length
            core_next.rst.pin_oe = 1'b1; // see R5, R7
            core_next.pulse_cnt  = 16'h0001 << mode_reg.pulse_len;
            core_next.state      = RPM_PULSE;
         end
         RPM_PULSE: begin
            if (core_reg.slow_en) begin
               if (core_reg.pulse_cnt == 16'h0001) begin
                  core_next.rst.pin_oe = 1'b0; // see R6
                  core_next.state      = RPM_WAIT;
               end else begin
                  core_next.pulse_cnt = core_reg.pulse_cnt - 16'h0001;
               end
            end
         end
         RPM_WAIT: begin
            // Release resets only after the pin has risen again
            if (core_reg.slow_en && core_reg.sync2) begin
               core_next.rst.proc_n   = 1'b1;
               core_next.rst.periph_n = 1'b1;
               core_next.state        = RPM_IDLE;
            end
         end
      endcase
      // Interrupt mask written by software
      if (do_write && core_reg.aw_addr == `RPM_OFS_IRQ_MASK && core_reg.w_strb[0]) begin
         core_next.irq_mask = core_reg.w_data[0];
      end
      core_next.irq = core_next.usr_status && mode_reg.urst_irq_en && core_next.irq_mask; // see R15, R17
      // Write channel capture in either order
      if (s_axi_awvalid && s_axi_awready) begin
         core_next.aw_got  = 1'b1;
         core_next.aw_addr = {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         core_next.w_got  = 1'b1;
         core_next.w_data = s_axi_wdata;
         core_next.w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         core_next.bvalid = 1'b1;
         core_next.bresp  = is_mapped(core_reg.aw_addr) ? `RPM_RESP_OKAY : `RPM_RESP_DECERR;
      end
      if (core_reg.bvalid && s_axi_bready) begin
         core_next.bvalid = 1'b0;
         core_next.aw_got = 1'b0;
         core_next.w_got  = 1'b0;
      end
      // Read channel
      if (do_read) begin
         core_next.rvalid = 1'b1;
         core_next.rresp  = is_mapped({s_axi_araddr[11:2], 2'b00}) ? `RPM_RESP_OKAY : `RPM_RESP_DECERR;
         core_next.rdata  = 32'h0000_0000;
         unique case ({s_axi_araddr[11:2], 2'b00})
            `RPM_OFS_MODE: begin
               core_next.rdata[`RPM_BIT_URST_EN]     = mode_reg.urst_en;
               core_next.rdata[`RPM_BIT_URST_IRQ_EN] = mode_reg.urst_irq_en;
               core_next.rdata[`RPM_LSB_PULSE_LEN +: `RPM_W_PULSE_LEN] = mode_reg.pulse_len;
            end
            `RPM_OFS_STATUS: begin
               core_next.rdata[`RPM_BIT_USR_STATUS] = core_reg.usr_status;
               core_next.rdata[`RPM_BIT_PIN_LEVEL]  = core_reg.pin_smp; // see R12
            end
            `RPM_OFS_IRQ_MASK: core_next.rdata[0] = core_reg.irq_mask;
            default: core_next.rdata = 32'h0000_0000;
         endcase
      end
      if (core_reg.rvalid && s_axi_rready) begin
         core_next.rvalid = 1'b0;
      end
   end

   // Mode register update; only the io supply reset touches it
   always_comb begin
      mode_next = mode_reg;
      if (do_write && core_reg.aw_addr == `RPM_OFS_MODE) begin
         if (core_reg.w_strb[0]) begin
            mode_next.urst_en     = core_reg.w_data[`RPM_BIT_URST_EN];
            mode_next.urst_irq_en = core_reg.w_data[`RPM_BIT_URST_IRQ_EN];
         end
         if (core_reg.w_strb[1]) begin
            mode_next.pulse_len = core_reg.w_data[`RPM_LSB_PULSE_LEN +: `RPM_W_PULSE_LEN];
         end
      end
   end

   // Core state, cleared by the core reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_reg       <= '0;
         core_reg.state <= RPM_IDLE;
         core_reg.sync1 <= 1'b1;
         core_reg.sync2 <= 1'b1;
         core_reg.pin_smp <= 1'b1;
         core_reg.rst.proc_n   <= 1'b1;
         core_reg.rst.periph_n <= 1'b1;
      end else begin
         core_reg <= core_next;
      end
   end

   // Mode register survives core reset while the io supply is up
   always_ff @(posedge aclk) begin
      if (!io_supply_resetn) begin
         mode_reg.urst_en     <= MODE_RST[`RPM_BIT_URST_EN];
         mode_reg.urst_irq_en <= MODE_RST[`RPM_BIT_URST_IRQ_EN];
         mode_reg.pulse_len   <= MODE_RST[`RPM_LSB_PULSE_LEN +: `RPM_W_PULSE_LEN];
      end else begin
         mode_reg <= mode_next; // see R8
      end
   end

   // Ready signals come from flip-flops via the held state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_awready <= !core_next.aw_got && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !core_next.w_got && !(s_axi_wvalid && s_axi_wready);
         s_axi_arready <= !core_next.rvalid && !do_read;
      end
   end

   // Outputs straight from the state flops, except ext_rst_out which is tied low
   assign s_axi_bvalid       = core_reg.bvalid;
   assign s_axi_bresp        = core_reg.bresp;
   assign s_axi_rvalid       = core_reg.rvalid;
   assign s_axi_rdata        = core_reg.rdata;
   assign s_axi_rresp        = core_reg.rresp;
   assign ext_rst_out        = 1'b0;
   assign ext_rst_oe         = core_reg.rst.pin_oe; // see R7
   assign cpu_reset_n        = core_reg.rst.proc_n; // see R2
   assign peripheral_reset_n = core_reg.rst.periph_n; // see R3
   assign irq                = core_reg.irq;

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Leading delay keeps the reset edges inside the disabled window
   sync_two_flop_a: assert property (##2 core_reg.sync2 == $past(ext_rst_in, 2)) // see R16
      else $error("sync path broken");
   pin_drive_req_a: assert property (ext_rst_oe |-> core_reg.state inside {RPM_PULSE, RPM_WAIT}) // see R7
      else $error("pin driven without request");
   own_drive_mask_a: assert property (ext_rst_oe && !core_reg.usr_status
                                      |=> !core_reg.usr_status) // see R18
      else $error("own pulse seen as user reset");
   status_set_a: assert property (pin_low_evt |=> core_reg.usr_status) // see R13
      else $error("status not set");
   status_hold_a: assert property (core_reg.usr_status && !rd_status
                                   |=> core_reg.usr_status) // see R14
      else $error("status lost without read");
   irq_clear_a: assert property (irq && rd_status && !pin_low_evt
                                 |=> !irq) // see R17
      else $error("irq not cleared by status read");
   irq_no_reset_a: assert property (pin_low_evt && mode_reg.urst_irq_en && core_reg.state == RPM_IDLE
                                    && !periph_event && !sw_proc && !sw_periph |=> cpu_reset_n) // see R15
      else $error("reset instead of irq");
   pin_sample_a: assert property (!core_reg.slow_en |=> $stable(core_reg.pin_smp)) // see R9
      else $error("pin sampled off the slow tick");
   periph_reset_a: assert property (periph_event && core_reg.state == RPM_IDLE |=> !cpu_reset_n && !peripheral_reset_n) // see R3
      else $error("peripheral event missed");
   pulse_end_a: assert property ($fell(ext_rst_oe) && $past(aresetn) |-> core_reg.state == RPM_WAIT) // see R6
      else $error("pin released outside pulse end");
   usr_disabled_a: assert property (pin_low_evt && !mode_reg.urst_en && core_reg.state == RPM_IDLE
                                    && !periph_event && !sw_proc && !sw_periph && !sw_ext
                                    |=> core_reg.state == RPM_IDLE) // see R11
      else $error("disabled user reset fired");
   user_reset_a: assert property (usr_trig && core_reg.state == RPM_IDLE |=> !cpu_reset_n && !peripheral_reset_n) // see R10
      else $error("user reset missed");

   usr_reset_c: cover property (usr_trig ##1 !cpu_reset_n);
   irq_raise_c: cover property (pin_low_evt && mode_reg.urst_irq_en ##1 irq);
   sw_pulse_c:  cover property (sw_ext ##[1:20] ext_rst_oe);
   // Status clear and peripheral reset are the other paths the bench walks
   status_clear_c: cover property (core_reg.usr_status && rd_status ##1 !core_reg.usr_status);
   periph_reset_c: cover property (periph_event ##1 !peripheral_reset_n);

endmodule : rpm_top
